// *** dv/lps_chipset.sv ***
`timescale 1ns/1ns
module lps_chipset (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       stop_cmd,
   input  wire logic       grant_seen,
   input  wire logic [3:0] ack_delay,
   input  wire logic       special_bus_cycle,
   output logic            stop_clock_request,
   output logic            ack_response
);
   logic [3:0] wait_cnt;
   // Stop-clock rises on command and falls only after grant was seen.
   // The stop-clock register ignores device reset, so the request survives it.
   // An unknown level at power-up settles low at the first edge.
   always_ff @(posedge pclk) begin
      if (stop_cmd) begin
         stop_clock_request <= 1'b1;
      end else if (grant_seen || stop_clock_request !== 1'b1) begin
         stop_clock_request <= 1'b0;
      end
   end
   // Answers each acknowledge cycle after a chosen, variable delay.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt     <= 4'h0;
         ack_response <= 1'b0;
      end else begin
         ack_response <= 1'b0;
         if (special_bus_cycle && !ack_response) begin
            if (wait_cnt == ack_delay) begin
               ack_response <= 1'b1;
               wait_cnt     <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule

// *** dv/test_cpu_low_power_state_control.sv ***
`timescale 1ns/1ns
`include "lps_regs.svh"
module test_cpu_low_power_state_control import lps_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, stop_cmd, grant_seen;
   logic [1:0]  core_halt_req, local_irq_pins, bus_request_pins;
   logic        stop_clock_request, snoop_active, snoop_done, bus_irq;
   logic        system_management_irq_pin, soft_init_pin;
   logic        bus_fatal_restart_pin, self_test_strap;
   logic        check_error_observe_strap, fatal_restart_observe_strap;
   logic        ack_response, interrupt_enable_flag, special_bus_cycle;
   logic [1:0]  core_halted, special_bus_cycle_core, arbitration_id;
   logic        pending_break_event_out, snoop_service, output_tristate;
   logic [7:0]  core_ratio;
   logic [5:0]  voltage_id_code;
   logic [4:0]  latched_events;
   logic        run_self_test, check_error_observe_off;
   logic        fatal_restart_observe_off;
   logic [3:0]  ack_delay;
   int          err_total, checks, n, k;

   lps_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .core_halt_req,
      .stop_clock_request, .snoop_active, .snoop_done, .bus_irq,
      .system_management_irq_pin, .soft_init_pin, .bus_fatal_restart_pin,
      .local_irq_pins, .self_test_strap, .check_error_observe_strap,
      .fatal_restart_observe_strap, .bus_request_pins, .ack_response,
      .interrupt_enable_flag, .core_halted, .special_bus_cycle,
      .special_bus_cycle_core, .pending_break_event_out, .snoop_service,
      .core_ratio, .voltage_id_code, .latched_events, .output_tristate,
      .run_self_test, .check_error_observe_off, .fatal_restart_observe_off,
      .arbitration_id);
   lps_chipset chipset (.pclk, .presetn, .stop_cmd, .grant_seen, .ack_delay,
      .special_bus_cycle, .stop_clock_request, .ack_response);

   // Bus clock, 40 ns period.
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic chk(input string s, input logic [31:0] x,
                      input logic [31:0] g);
      checks++;
      if (g !== x) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", s, x, g);
      end
   endtask

   // One register bus transfer; entered just after a rising edge.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Polls the state field until it matches or the tries run out.
   task automatic wait_st(input lps_state_t s, input int lim);
      for (int i = 0; i < lim; i++) begin
         apb(1'b0, `LPS_ADDR_STATUS, 32'h0);
         if (q[3:0] === 4'(s)) break;
      end
      chk(s.name(), 32'(s), {28'h0, q[3:0]});
   endtask

   task automatic ev(input int k, input logic v);
      case (k)
         0: system_management_irq_pin <= v;
         1: soft_init_pin             <= v;
         2: bus_fatal_restart_pin     <= v;
         3: local_irq_pins            <= {1'b0, v};
         default: bus_irq             <= v;
      endcase
   endtask

   task automatic pulse(input int k);
      ev(k, 1'b1);
      repeat (2) @(posedge pclk);
      ev(k, 1'b0);
      @(posedge pclk);
   endtask

   task automatic snoop(input lps_state_t s, input lps_state_t b);
      snoop_active <= 1'b1;
      wait_st(s, 40);
      chk("snoop_service", 1, snoop_service);
      snoop_active <= 1'b0;
      snoop_done   <= 1'b1;
      @(posedge pclk);
      snoop_done   <= 1'b0;
      wait_st(b, 40);
   endtask

   // Resets with the given straps, then inverts the other strap pins and drives the management irq pin low.
   task automatic do_reset(input logic [5:0] st);
      {system_management_irq_pin, self_test_strap,
       check_error_observe_strap, fatal_restart_observe_strap,
       bus_request_pins} <= st;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      {system_management_irq_pin, self_test_strap,
       check_error_observe_strap, fatal_restart_observe_strap,
       bus_request_pins} <= {1'b0, ~st[4:0]};
      repeat (2) @(posedge pclk);
      apb(1'b0, `LPS_ADDR_STRAP, 32'h0);
      chk("strap reg", {26'h0, st}, q);
      chk("strap out", {26'h0, st}, {26'h0, output_tristate, run_self_test,
          check_error_observe_off, fatal_restart_observe_off,
          arbitration_id});
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cuts a hang short well past the expected run length.
   initial begin
      #(40 * 40000);
      err_total++;
      give_verdict();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {core_halt_req, local_irq_pins, snoop_active, snoop_done} = '0;
      {bus_irq, soft_init_pin, bus_fatal_restart_pin} = '0;
      {stop_cmd, grant_seen, interrupt_enable_flag} = '0;
      ack_delay = 4'h3;
      // Only strap lines are driven during reset.
      do_reset(6'h2A);
      do_reset(6'h15);
      apb(1'b0, `LPS_ADDR_RATIO, 32'h0);
      chk("ratio reg", 32'h0000060C, q);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped err", 1, e);
      $display("test straps done");
      core_halt_req <= 2'b01;
      repeat (6) @(posedge pclk);
      chk("one core", 2'b01, core_halted);
      for (k = 0; k < 5; k++) begin
         core_halt_req <= 2'b11;
         wait_st(LPS_HALT, 40);
         if (k == 0) snoop(LPS_HALT_SNOOP, LPS_HALT);
         core_halt_req <= 2'b00;
         pulse(k);
         wait_st(LPS_NORMAL, 40);
      end
      $display("test halt done");
      apb(1'b1, `LPS_ADDR_CTRL, 32'h1);
      core_halt_req <= 2'b10;
      repeat (40) @(posedge pclk);
      chk("no deep one core", 8'h0C, core_ratio);
      core_halt_req <= 2'b11;
      for (n = 0; n < 200 && core_ratio === 8'h0C; n++) @(posedge pclk);
      chk("ratio low first", 8'h06, core_ratio);
      chk("vid still high", 6'h20, voltage_id_code);
      wait_st(LPS_DEEP, 40);
      chk("vid low", 6'h10, voltage_id_code);
      snoop(LPS_DEEP_SNOOP, LPS_DEEP);
      chk("ratio kept", 8'h06, core_ratio);
      ev(4, 1'b1);
      core_halt_req <= 2'b00;
      for (n = 0; n < 200 && voltage_id_code === 6'h10; n++) @(posedge pclk);
      chk("vid back first", 6'h20, voltage_id_code);
      chk("ratio waits", 8'h06, core_ratio);
      ev(4, 1'b0);
      wait_st(LPS_NORMAL, 40);
      chk("ratio back", 8'h0C, core_ratio);
      apb(1'b1, `LPS_ADDR_RATIO, 32'h0606);
      core_halt_req <= 2'b11;
      wait_st(LPS_HALT, 40);
      chk("vid at lowest", 6'h20, voltage_id_code);
      core_halt_req <= 2'b00;
      pulse(4);
      wait_st(LPS_NORMAL, 40);
      apb(1'b1, `LPS_ADDR_RATIO, 32'h060C);
      apb(1'b1, `LPS_ADDR_CTRL, 32'h0);
      $display("test deep halt done");
      stop_cmd <= 1'b1;
      n = 0;
      q = 32'h0000_0000;
      for (k = 0; k < 300 && n < 2; k++) begin
         @(posedge pclk);
         if (ack_response === 1'b1) n++;
         if (special_bus_cycle === 1'b1)
            q[1:0] = q[1:0] | special_bus_cycle_core;
      end
      chk("ack cycles", 2, n);
      chk("ack cores", 32'h0000_0003, q);
      repeat (16) @(posedge pclk);
      wait_st(LPS_GRANT_WAIT, 1);
      repeat (1) @(posedge pclk);
      wait_st(LPS_GRANT, 1);
      do_reset(6'h00);
      wait_st(LPS_GRANT, 1);
      pulse(0);
      pulse(0);
      pulse(3);
      chk("latched once", 5'b10010, latched_events);
      pulse(4);
      chk("bus irq latched", 5'b10011, latched_events);
      chk("pending break", 1, pending_break_event_out);
      snoop(LPS_GRANT_SNOOP, LPS_GRANT);
      grant_seen <= 1'b1;
      stop_cmd   <= 1'b0;
      wait_st(LPS_NORMAL, 40);
      chk("events serviced", 0, latched_events);
      grant_seen <= 1'b0;
      $display("test stop grant done");
      ack_delay     <= 4'h0;
      core_halt_req <= 2'b11;
      wait_st(LPS_HALT, 40);
      stop_cmd <= 1'b1;
      wait_st(LPS_GRANT, 100);
      grant_seen <= 1'b1;
      stop_cmd   <= 1'b0;
      wait_st(LPS_HALT, 40);
      $display("test halt stop done");
      give_verdict();
   end
endmodule

// *** hdl/lps_ctrl.sv ***
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "lps_regs.svh"
module lps_ctrl import lps_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  core_halt_req,
   input  wire logic        stop_clock_request,
   input  wire logic        snoop_active,
   input  wire logic        snoop_done,
   input  wire logic        bus_irq,
   input  wire logic        system_management_irq_pin,
   input  wire logic        soft_init_pin,
   input  wire logic        bus_fatal_restart_pin,
   input  wire logic [1:0]  local_irq_pins,
   input  wire logic        self_test_strap,
   input  wire logic        check_error_observe_strap,
   input  wire logic        fatal_restart_observe_strap,
   input  wire logic [1:0]  bus_request_pins,
   input  wire logic        ack_response,
   input  wire logic        interrupt_enable_flag,
   output logic [1:0]       core_halted,
   output logic             special_bus_cycle,
   output logic [1:0]       special_bus_cycle_core,
   output logic             pending_break_event_out,
   output logic             snoop_service,
   output logic [7:0]       core_ratio,
   output logic [5:0]       voltage_id_code,
   output logic [4:0]       latched_events,
   output logic             output_tristate,
   output logic             run_self_test,
   output logic             check_error_observe_off,
   output logic             fatal_restart_observe_off,
   output logic [1:0]       arbitration_id
);
   lps_state_t state_reg;
   lps_state_t state_next;
   logic        deep_en_reg;
   logic [7:0]  ratio_reg;
   logic [7:0]  ratio_min_reg;
   logic [4:0]  grant_cnt_reg;
   logic [3:0]  step_cnt_reg;
   logic [1:0]  ack_cnt_reg;
   logic [1:0]  grant_return_reg;
   logic [5:0]  strap_reg;
   logic        capture_reg;
   logic        break_evt;
   logic        halt_wake;
   logic        step_done;
   logic        apb_wr;
   logic        apb_rd;

   // Tells whether any latched event bit is set.
   function automatic logic any_event(input logic [4:0] ev);
      any_event = |ev;
   endfunction

   // Deep halt needs both cores halted, the enable, and room to drop ratio.
   function automatic logic deep_ok(input logic [1:0] req,
                                    input logic       en,
                                    input logic [7:0] nom,
                                    input logic [7:0] low);
      deep_ok = &req && en && nom != low;
   endfunction

   // A break is any wakeup source seen by a halted core.
   assign break_evt = system_management_irq_pin | soft_init_pin |
                      bus_fatal_restart_pin | (|local_irq_pins) | bus_irq;
   assign halt_wake = break_evt; // RQ6
   assign step_done = (step_cnt_reg == `LPS_STEP_WAIT);
   assign apb_wr    = psel & penable & pwrite;
   assign apb_rd    = psel & ~pwrite;

   // Straps are caught on the first clock after reset release and then held.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_reg <= 1'b1;
         strap_reg   <= 6'h00;
      end else if (capture_reg) begin
         capture_reg <= 1'b0; // RQ2
         strap_reg   <= {system_management_irq_pin, self_test_strap,
                         check_error_observe_strap,
                         fatal_restart_observe_strap,
                         bus_request_pins}; // RQ1 RQ3
      end
   end

   // Strap outputs decode the captured options.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_tristate           <= 1'b0;
         run_self_test             <= 1'b0;
         check_error_observe_off   <= 1'b0;
         fatal_restart_observe_off <= 1'b0;
         arbitration_id            <= 2'h0;
      end else begin
         output_tristate           <= strap_reg[5]; // RQ3
         run_self_test             <= strap_reg[4];
         check_error_observe_off   <= strap_reg[3];
         fatal_restart_observe_off <= strap_reg[2];
         arbitration_id            <= strap_reg[1:0];
      end
   end

   // Next-state logic of the low-power machine.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LPS_NORMAL: begin
            // A reset during a held stop-clock goes straight back to grant.
            if (stop_clock_request)
               state_next = capture_reg ? LPS_GRANT : LPS_ACK; // RQ14 RQ18
            else if (deep_ok(core_halt_req, deep_en_reg, ratio_reg,
                             ratio_min_reg))
               state_next = LPS_DEEP_RATIO; // RQ9 RQ23
            else if (|core_halt_req)
               state_next = LPS_HALT; // RQ5 RQ10
         end
         LPS_HALT: begin
            if (stop_clock_request)
               state_next = LPS_ACK; // RQ7
            else if (halt_wake)
               state_next = LPS_NORMAL; // RQ6
            else if (deep_ok(core_halt_req, deep_en_reg, ratio_reg,
                             ratio_min_reg))
               state_next = LPS_DEEP_RATIO; // RQ9 RQ10
            else if (snoop_active)
               state_next = LPS_HALT_SNOOP; // RQ8 RQ22
         end
         LPS_HALT_SNOOP:
            if (snoop_done || bus_irq)
               state_next = LPS_HALT; // RQ22
         LPS_DEEP_RATIO:
            if (step_done)
               state_next = LPS_DEEP_VID; // RQ11
         LPS_DEEP_VID:
            if (step_done)
               state_next = LPS_DEEP;
         LPS_DEEP: begin
            if (halt_wake || stop_clock_request)
               state_next = LPS_EXIT_VID; // RQ12
            else if (snoop_active)
               state_next = LPS_DEEP_SNOOP; // RQ13
         end
         LPS_DEEP_SNOOP:
            if (snoop_done || bus_irq)
               state_next = LPS_DEEP; // RQ22
         LPS_EXIT_VID:
            if (step_done)
               state_next = LPS_EXIT_RATIO; // RQ12
         LPS_EXIT_RATIO:
            if (step_done)
               state_next = LPS_NORMAL;
         LPS_ACK:
            if (ack_response && ack_cnt_reg == 2'd1)
               state_next = LPS_GRANT_WAIT; // RQ14
         LPS_GRANT_WAIT:
            if (grant_cnt_reg == `LPS_GRANT_DELAY - 5'd1)
               state_next = LPS_GRANT; // RQ15
         LPS_GRANT: begin
            if (!stop_clock_request)
               state_next = grant_return_reg[0] ? LPS_HALT
                                                : LPS_NORMAL; // RQ7 RQ18
            else if (snoop_active || bus_irq)
               state_next = LPS_GRANT_SNOOP; // RQ20 RQ22
         end
         LPS_GRANT_SNOOP:
            if (snoop_done || bus_irq)
               state_next = LPS_GRANT; // RQ22
      endcase
   end

   // State register; reset initialises but a held stop-clock returns to grant.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state_reg <= LPS_NORMAL;
      else
         state_reg <= state_next; // RQ18
   end

   // Remembers whether the stop-clock episode started from halt.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         grant_return_reg <= 2'b00;
      else if (state_reg != LPS_ACK && state_next == LPS_ACK)
         grant_return_reg <= {1'b0, state_reg != LPS_NORMAL}; // RQ7
   end

   // Settle counter for each ratio or voltage step.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         step_cnt_reg <= 4'h0;
      else if (state_next != state_reg)
         step_cnt_reg <= 4'h0;
      else if (!step_done)
         step_cnt_reg <= step_cnt_reg + 4'h1;
   end

   // Counts bus clocks after the final acknowledge response phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         grant_cnt_reg <= 5'd0;
      else if (state_reg == LPS_GRANT_WAIT)
         grant_cnt_reg <= grant_cnt_reg + 5'd1; // RQ15
      else
         grant_cnt_reg <= 5'd0;
   end

   // One acknowledge special cycle per core, each ended by its response.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_cnt_reg            <= 2'd0;
         special_bus_cycle      <= 1'b0;
         special_bus_cycle_core <= 2'b00;
      end else if (state_reg == LPS_ACK) begin
         special_bus_cycle      <= ~ack_response; // RQ14
         special_bus_cycle_core <= ack_cnt_reg[0] ? 2'b10 : 2'b01;
         if (ack_response)
            ack_cnt_reg <= ack_cnt_reg + 2'd1;
      end else begin
         ack_cnt_reg            <= 2'd0;
         special_bus_cycle      <= 1'b0;
         special_bus_cycle_core <= 2'b00;
      end
   end

   // Ratio and voltage id follow the entry and exit ordering.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_ratio      <= `LPS_RATIO_RST;
         voltage_id_code <= `LPS_VID_HI;
      end else unique case (state_reg)
         LPS_DEEP_RATIO: core_ratio      <= ratio_min_reg; // RQ11
         LPS_DEEP_VID:   voltage_id_code <= `LPS_VID_LO;   // RQ11
         LPS_EXIT_VID:   voltage_id_code <= `LPS_VID_HI;   // RQ12
         LPS_EXIT_RATIO: core_ratio      <= ratio_reg;     // RQ12
         default: ;
      endcase
   end

   // Events in grant are latched once each and released back in Normal.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         latched_events <= 5'h00;
      else if (state_reg == LPS_GRANT || state_reg == LPS_GRANT_SNOOP)
         latched_events <= latched_events |
            {system_management_irq_pin, soft_init_pin,
             bus_fatal_restart_pin, |local_irq_pins, bus_irq}; // RQ19 RQ20
      else if (state_reg == LPS_NORMAL)
         latched_events <= 5'h00;
   end

   // Pending break ignores the interrupt enable flag on purpose.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pending_break_event_out <= 1'b0;
      else
         pending_break_event_out <= (state_reg == LPS_GRANT ||
            state_reg == LPS_GRANT_SNOOP) &&
            (any_event(latched_events) |
             (interrupt_enable_flag & 1'b0)); // RQ21
   end

   // Per-core halt indication and snoop service strobe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_halted   <= 2'b00;
         snoop_service <= 1'b0;
      end else begin
         core_halted   <= (state_reg == LPS_NORMAL) ? 2'b00 :
                          (state_reg == LPS_HALT ||
                           state_reg == LPS_HALT_SNOOP) ?
                          core_halt_req : 2'b11; // RQ5
         snoop_service <= state_reg == LPS_HALT_SNOOP ||
                          state_reg == LPS_DEEP_SNOOP ||
                          state_reg == LPS_GRANT_SNOOP; // RQ8 RQ13
      end
   end

   // APB register writes: control, nominal and lowest ratio.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_en_reg   <= 1'b0;
         ratio_reg     <= `LPS_RATIO_RST;
         ratio_min_reg <= `LPS_RATIO_MIN_RST;
      end else if (apb_wr) begin
         if (paddr == `LPS_ADDR_CTRL)
            deep_en_reg <= pwdata[`LPS_CTRL_DEEP_EN]; // RQ23
         if (paddr == `LPS_ADDR_RATIO) begin
            ratio_reg     <= pwdata[7:0];
            ratio_min_reg <= pwdata[15:8];
         end
      end
   end

   // APB read data, zero-wait answer, error on unmapped address.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable &
                    paddr != `LPS_ADDR_CTRL && paddr != `LPS_ADDR_STATUS &&
                    paddr != `LPS_ADDR_STRAP && paddr != `LPS_ADDR_RATIO;
         prdata  <= 32'h0000_0000;
         if (apb_rd && !penable)
            unique case (paddr)
               `LPS_ADDR_CTRL:   prdata <= {31'h0, deep_en_reg};
               `LPS_ADDR_STATUS: prdata <= {21'h0, latched_events,
                                            2'h0, state_reg};
               `LPS_ADDR_STRAP:  prdata <= {26'h0, strap_reg};
               `LPS_ADDR_RATIO:  prdata <= {16'h0, ratio_min_reg,
                                            ratio_reg};
               default:          prdata <= 32'h0000_0000;
            endcase
      end
   end

   // Stop-grant follows the last acknowledge response by the counted delay.
   a_grant_delay: assert property ( // RQ15
      @(posedge pclk) disable iff (!presetn)
      state_reg == LPS_GRANT && $past(state_reg) == LPS_GRANT_WAIT |->
      $past(ack_response, `LPS_GRANT_DELAY + 1))
      else $error("grant entered at wrong count");
   // Ratio drops before voltage on entry.
   a_deep_order: assert property ( // RQ11
      @(posedge pclk) disable iff (!presetn)
      $fell(voltage_id_code == `LPS_VID_HI) |-> core_ratio == ratio_min_reg)
      else $error("voltage lowered before ratio");
   // Voltage restored before ratio on exit.
   a_exit_order: assert property ( // RQ12
      @(posedge pclk) disable iff (!presetn)
      state_reg == LPS_EXIT_RATIO |-> voltage_id_code == `LPS_VID_HI)
      else $error("ratio restored before voltage");
   // Deep halt needs enable and both cores halted.
   a_deep_entry: assert property ( // RQ9
      @(posedge pclk) disable iff (!presetn)
      state_reg != LPS_DEEP_RATIO && state_next == LPS_DEEP_RATIO |->
      deep_en_reg && &core_halt_req && ratio_reg != ratio_min_reg)
      else $error("deep halt entered without conditions");
   // Pending break only in grant with an event latched.
   a_break_out: assert property ( // RQ21
      @(posedge pclk) disable iff (!presetn)
      pending_break_event_out |-> $past(latched_events) != 5'h00)
      else $error("pending break without event");
   // Grant releases to halt when it came from halt.
   a_grant_halt: assert property ( // RQ7
      @(posedge pclk) disable iff (!presetn)
      state_reg == LPS_GRANT && !stop_clock_request && grant_return_reg[0]
      |=> state_reg == LPS_HALT)
      else $error("grant did not resume halt");
   // Halt wakes to Normal on a break event.
   a_halt_wake: assert property ( // RQ6
      @(posedge pclk) disable iff (!presetn)
      state_reg == LPS_HALT && !stop_clock_request && break_evt
      |=> state_reg == LPS_NORMAL)
      else $error("halt missed wake");
   // Straps hold after capture.
   a_strap_hold: assert property ( // RQ2
      @(posedge pclk) disable iff (!presetn)
      !capture_reg && !$past(capture_reg) |-> $stable(strap_reg))
      else $error("strap changed");
   // A reset while stop-clock is held lands back in stop-grant at once.
   a_reset_grant: assert property ( // RQ18
      @(posedge pclk) disable iff (!presetn)
      capture_reg && stop_clock_request |=> state_reg == LPS_GRANT)
      else $error("reset left stop grant");
endmodule

// *** hdl/lps_pkg.sv ***
package lps_pkg;
   typedef enum logic [3:0] {
      LPS_NORMAL, LPS_HALT, LPS_HALT_SNOOP, LPS_DEEP_RATIO, LPS_DEEP_VID,
      LPS_DEEP, LPS_DEEP_SNOOP, LPS_EXIT_VID, LPS_EXIT_RATIO,
      LPS_ACK, LPS_GRANT_WAIT, LPS_GRANT, LPS_GRANT_SNOOP
   } lps_state_t;
endpackage

// *** hdl/lps_regs.svh ***
// Operation
// RQ1 - Straps are captured when reset goes from asserted to deasserted.
// RQ2 - Captured straps hold until the next reset; every reset recaptures.
// RQ3 - Asserted strap selects option: tristate, self test, observe disables, id.
// RQ4 - Outside system keeps non-strap address lines deasserted during reset.
// RQ5 - A halting core halts alone; the other core keeps running.
// RQ6 - Halt returns to Normal on management irq, init, restart, local or bus irq.
// RQ7 - Stop-clock in halt enters Stop-Grant; release resumes halt.
// RQ8 - While halted, snoops are serviced and interrupts accepted.
// RQ9 - Deep halt only when both cores halted and the feature is enabled.
// RQ10 - At the lowest ratio, ordinary halt is used instead of deep halt.
// RQ11 - Deep halt entry lowers ratio first, then voltage id; bus unchanged.
// RQ12 - Deep halt exit restores voltage id first, then the ratio.
// RQ13 - Snoops are processed while in deep halt.
// RQ14 - Stop-clock issues one acknowledge special cycle per core; both enter grant.
// RQ15 - Stop-Grant is entered 20 bus clocks after the acknowledge response phase.
// RQ16 - System releases stop-clock only after both cores reach Stop-Grant.
// RQ17 - Chipset tolerates a variable number of acknowledge cycles.
// RQ18 - Reset in Stop-Grant initialises but stays there until stop-clock drops.
// RQ19 - Events in Stop-Grant are latched once each, serviced after Normal return.
// RQ20 - Stop-Grant keeps snooping and latches bus-delivered interrupts.
// RQ21 - Pending-break asserts in Stop-Grant while any latched interrupt pends.
// RQ22 - Snoop or interrupt moves to a snoop state until serviced or latched.
// RQ23 - Deep halt enable is software writable; clear means ordinary halt states.
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH
`define LPS_ADDR_CTRL     12'h000
`define LPS_ADDR_STATUS   12'h004
`define LPS_ADDR_STRAP    12'h008
`define LPS_ADDR_RATIO    12'h00C
`define LPS_CTRL_DEEP_EN  0
`define LPS_GRANT_DELAY   5'd20
`define LPS_STEP_WAIT     4'hF
`define LPS_RATIO_RST     8'h0C
`define LPS_RATIO_MIN_RST 8'h06
`define LPS_VID_HI        6'h20
`define LPS_VID_LO        6'h10
`endif
